// >>> src/fwc_pkg.sv
// package for the flash write command control block
// assumes a 16-bit register view placed in the low half of 32-bit wishbone words
package fwc_pkg;
    localparam int ADR_W = 8;
    localparam logic [7:0] OFF_CTL_LO = 8'h00;
    localparam logic [7:0] OFF_CTL_HI = 8'h04;
    localparam logic [7:0] OFF_D0_LO = 8'h08;
    localparam logic [7:0] OFF_D0_HI = 8'h0c;
    localparam logic [7:0] OFF_D1_LO = 8'h10;
    localparam logic [7:0] OFF_D1_HI = 8'h14;
    localparam logic [7:0] OFF_ADR_LO = 8'h18;
    localparam logic [7:0] OFF_ADR_HI = 8'h1c;
    localparam logic [7:0] OFF_ERR = 8'h20;
    localparam logic [7:0] OFF_SECT = 8'h24;
    // control low fields
    localparam int CL_BUSY = 3;
    localparam int CL_LOCK = 4;
    // control high fields
    localparam int CH_SPR = 8;
    localparam int CH_SER = 11;
    localparam int CH_DOUBLE_WORD_PROG_SELECT = 12;
    localparam int CH_WPG = 13;
    localparam int CH_PAUSE = 14;
    localparam int CH_START = 15;
    // error register fields
    localparam int ER_ERR = 0;
    localparam int ER_SEQ = 1;
    localparam logic [15:0] DATA_RST = 16'hffff;
    localparam logic [15:0] INVALID_DAT = 16'hffff;
    // protection register window, ends kept as printed
    localparam logic [23:0] PROT_END_A = 24'h0e8fb0;
    localparam logic [23:0] PROT_END_B = 24'h08dfbf;
    // test sector in the write map
    localparam logic [23:0] TEST_HI = 24'h001fff;
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_WORD = 3'h1,
        OP_DWORD = 3'h2,
        OP_PREP = 3'h3,
        OP_ERASE = 3'h4,
        OP_PROT = 3'h5
    } fwc_op_e;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_PROG = 3'h1,
        ST_PREP = 3'h3,
        ST_ERASE = 3'h2,
        ST_PAUSE_REQUEST_E = 3'h6,
        ST_EPROG = 3'h7,
        ST_PAUSE_REQUEST_P = 3'h5
    } fwc_st_e;
endpackage

// >>> src/fwc_wb_port.sv
// classic wishbone slave handshake for the flash command registers
// assumes a single-cycle master that holds the request until ack
`timescale 1ns/1ps
`default_nettype none
module fwc_wb_port (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:0] rdata_i,
    output logic ack_o,
    output logic [31:0] dat_o,
    output logic rd_o,
    output logic wr_o
);
    logic req;

    // one access per request; ack drops the cycle after it is given
    assign req = cyc_i && stb_i && !ack_o;
    assign rd_o = req && !we_i;
    assign wr_o = req && we_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0;
        end else if (rd_o) begin
            dat_o <= rdata_i;
        end
    end
endmodule
`default_nettype wire

// >>> src/fwc_tgt_chk.sv
// target check for a requested flash write operation
// assumes operation, address and sector selection are stable registers
`timescale 1ns/1ps
`default_nettype none
module fwc_tgt_chk
    import fwc_pkg::*;
#(
    parameter int SECT_N = 8
) (
    input wire fwc_pkg::fwc_op_e op_i,
    input wire logic [23:0] addr_i,
    input wire logic [SECT_N-1:0] sect_i,
    output logic bad_o
);
    logic [23:0] lo;
    logic [23:0] hi;
    logic in_prot;
    logic in_test;

    // ends may be given in either order
    assign lo = (PROT_END_A < PROT_END_B) ? PROT_END_A : PROT_END_B;
    assign hi = (PROT_END_A < PROT_END_B) ? PROT_END_B : PROT_END_A;
    assign in_prot = (addr_i >= lo) && (addr_i <= hi);
    assign in_test = addr_i <= TEST_HI;

    always_comb begin
        case (op_i)
            OP_PROT: bad_o = !in_prot;
            OP_WORD: bad_o = in_test;
            OP_DWORD: bad_o = in_test || (addr_i[2:0] != 3'h0);
            OP_PREP: bad_o = (sect_i == '0);
            default: bad_o = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// >>> src/fwc_ctrl.sv
// flash write command control: control register zero, busy and lock flags
// assumes a program/erase engine on the same clock that pulses done at the end
`timescale 1ns/1ps
`default_nettype none
module fwc_ctrl #(
    parameter int SECT_N = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [fwc_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic bank_rd_i,
    input wire logic bank_wr_i,
    output logic bank_wr_ok_o,
    output logic trap_o,
    output logic eng_go_o,
    output fwc_pkg::fwc_op_e eng_op_o,
    output logic eng_hold_o,
    output logic [23:0] eng_addr_o,
    output logic [63:0] eng_data_o,
    output logic [SECT_N-1:0] eng_sect_o,
    input wire logic eng_done_i,
    input wire logic eng_fail_i
);
    import fwc_pkg::*;

    if (SECT_N < 1 || SECT_N > 16) begin : g_chk
        $error("SECT_N must lie in 1..16");
    end

    logic rd;
    logic wr;
    logic [31:0] rdata;
    logic [15:0] wd;
    logic [31:0] d0_r;
    logic [31:0] d1_r;
    logic [23:0] a_r;
    logic [1:0] err_r;
    logic [1:0] pend_r;
    logic [SECT_N-1:0] sect_r;
    logic spr_r;
    logic ser_r;
    logic double_word_prog_select_r;
    logic wpg_r;
    logic pause_r;
    logic start_r;
    logic busy_r;
    logic lock_r;
    logic bad_r;
    logic go_r;
    logic trap_r;
    logic wr_ok_r;
    fwc_op_e op_r;
    fwc_st_e st_r;
    fwc_st_e st_nxt;
    logic hold_r;
    fwc_op_e req_op;
    logic req_bad;
    logic ch_wr;
    logic [15:0] ch_new;
    logic go_req;
    logic accept;
    logic finish;
    logic suspend;
    logic n_spr;
    logic n_ser;
    logic n_double_word_prog_select;
    logic n_wpg;

    assign wd = wb_dat_i[15:0];

    // registers sitting behind the lock
    function automatic logic locked_reg(input logic [ADR_W-1:0] adr);
        locked_reg = (adr == OFF_CTL_HI) || (adr == OFF_D0_LO) || (adr == OFF_D0_HI)
            || (adr == OFF_D1_LO) || (adr == OFF_D1_HI) || (adr == OFF_ADR_LO)
            || (adr == OFF_ADR_HI) || (adr == OFF_ERR) || (adr == OFF_SECT);
    endfunction

    // byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [3:0] sel);
        merge = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
    endfunction

    fwc_wb_port fwc_wb_port_inst (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cyc_i(wb_cyc_i),
        .stb_i(wb_stb_i),
        .we_i(wb_we_i),
        .rdata_i(rdata),
        .ack_o(wb_ack_o),
        .dat_o(wb_dat_o),
        .rd_o(rd),
        .wr_o(wr)
    );

    // register write gated by the lock
    function automatic logic reg_wr(input logic w, input logic lk, input logic [ADR_W-1:0] a,
                                    input logic [ADR_W-1:0] off);
        reg_wr = w && !lk && (a == off);
    endfunction

    assign ch_wr = reg_wr(wr, lock_r, wb_adr_i, OFF_CTL_HI);
    assign ch_new = merge({start_r, pause_r, wpg_r, double_word_prog_select_r, ser_r, 2'b00, spr_r, 8'h00},
                          wd, wb_sel_i);
    assign go_req = ch_wr && ch_new[CH_START];
    assign n_spr = ch_new[CH_SPR];
    assign n_ser = ch_new[CH_SER];
    assign n_double_word_prog_select = ch_new[CH_DOUBLE_WORD_PROG_SELECT];
    assign n_wpg = ch_new[CH_WPG];

    // decide what a start request means in the present state
    always_comb begin
        req_op = OP_NONE;
        case (st_r)
            ST_IDLE: begin
                if (!n_spr && !n_ser && !n_double_word_prog_select && n_wpg) begin
                    req_op = OP_WORD;
                end else if (!n_spr && !n_ser && n_double_word_prog_select && !n_wpg) begin
                    req_op = OP_DWORD;
                end else if (!n_spr && n_ser && !n_double_word_prog_select && !n_wpg) begin
                    req_op = OP_PREP;
                end else if (n_spr && !n_ser && !n_double_word_prog_select && !n_wpg) begin
                    req_op = OP_PROT;
                end
            end
            ST_PAUSE_REQUEST_P: begin
                if (wpg_r && n_wpg && !n_double_word_prog_select && !n_ser && !n_spr) begin
                    req_op = OP_WORD;
                end else if (double_word_prog_select_r && n_double_word_prog_select && !n_wpg && !n_ser && !n_spr) begin
                    req_op = OP_DWORD;
                end
            end
            ST_PAUSE_REQUEST_E: begin
                if (n_wpg && !n_double_word_prog_select && !n_spr) begin
                    req_op = OP_WORD;
                end else if (n_double_word_prog_select && !n_wpg && !n_spr) begin
                    req_op = OP_DWORD;
                end else if (n_ser && !n_spr) begin
                    req_op = OP_ERASE;
                end
            end
            default: req_op = OP_NONE;
        endcase
    end

    // a pending pause blocks fresh starts but not resumes
    assign accept = go_req && !err_r[ER_ERR] && (req_op != OP_NONE)
        && !(st_r == ST_IDLE && (pause_r || ch_new[CH_PAUSE]));

    fwc_tgt_chk #(
        .SECT_N(SECT_N)
    ) fwc_tgt_chk_inst (
        .op_i(req_op),
        .addr_i(a_r),
        .sect_i(sect_r),
        .bad_o(req_bad)
    );

    // program inside erase suspend cannot be paused
    assign suspend = pause_r && !bad_r && ((st_r == ST_PROG && op_r != OP_PROT)
        || st_r == ST_PREP || st_r == ST_ERASE);
    assign finish = (st_r == ST_PROG || st_r == ST_ERASE || st_r == ST_EPROG
        || st_r == ST_PREP) && (eng_done_i || bad_r) && !go_r
        && !(st_r == ST_PREP && !eng_fail_i && !bad_r);

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_IDLE: begin
                if (accept) begin
                    st_nxt = (req_op == OP_PREP) ? ST_PREP : ST_PROG;
                end
            end
            ST_PROG: begin
                if (suspend) begin
                    st_nxt = ST_PAUSE_REQUEST_P;
                end else if (finish) begin
                    st_nxt = ST_IDLE;
                end
            end
            ST_PREP: begin
                if (suspend) begin
                    st_nxt = ST_PAUSE_REQUEST_E;
                end else if (finish) begin
                    st_nxt = ST_IDLE;
                end else if (eng_done_i && !go_r) begin
                    st_nxt = ST_ERASE;
                end
            end
            ST_ERASE: begin
                if (suspend) begin
                    st_nxt = ST_PAUSE_REQUEST_E;
                end else if (finish) begin
                    st_nxt = ST_IDLE;
                end
            end
            ST_PAUSE_REQUEST_P: begin
                if (accept) begin
                    st_nxt = ST_PROG;
                end
            end
            ST_PAUSE_REQUEST_E: begin
                if (accept) begin
                    st_nxt = (req_op == OP_ERASE) ? ST_ERASE : ST_EPROG;
                end
            end
            ST_EPROG: begin
                if (finish) begin
                    st_nxt = ST_PAUSE_REQUEST_E;
                end
            end
            default: st_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= ST_IDLE;
            hold_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            // registered from the next state so hold tracks the state flop exactly
            hold_r <= (st_nxt == ST_PAUSE_REQUEST_P) || (st_nxt == ST_PAUSE_REQUEST_E);
        end
    end

    // engine command
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            go_r <= 1'b0;
            op_r <= OP_NONE;
            bad_r <= 1'b0;
        end else if (accept) begin
            go_r <= !req_bad;
            op_r <= req_op;
            bad_r <= req_bad;
        end else if (st_r == ST_PREP && st_nxt == ST_ERASE) begin
            go_r <= 1'b1;
            op_r <= OP_ERASE;
        end else begin
            go_r <= 1'b0;
            if (finish || suspend) begin
                bad_r <= 1'b0;
            end
        end
    end

    // start, busy and lock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_r <= 1'b0;
            busy_r <= 1'b0;
            lock_r <= 1'b0;
        end else if (accept) begin
            start_r <= 1'b1;
            busy_r <= 1'b1;
            lock_r <= 1'b1;
        end else begin
            if (finish || suspend) begin
                start_r <= 1'b0;
                busy_r <= 1'b0;
            end
            if (!busy_r) begin
                lock_r <= 1'b0;
            end
        end
    end

    // select bits and pause
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            spr_r <= 1'b0;
            ser_r <= 1'b0;
            double_word_prog_select_r <= 1'b0;
            wpg_r <= 1'b0;
            pause_r <= 1'b0;
        end else begin
            if (ch_wr && st_r == ST_IDLE) begin
                spr_r <= n_spr;
                ser_r <= n_ser;
                double_word_prog_select_r <= n_double_word_prog_select;
                wpg_r <= n_wpg;
            end else if (ch_wr && st_r == ST_PAUSE_REQUEST_E) begin
                double_word_prog_select_r <= n_double_word_prog_select;
                wpg_r <= n_wpg;
            end else if (finish) begin
                spr_r <= 1'b0;
                double_word_prog_select_r <= 1'b0;
                wpg_r <= 1'b0;
                if (st_r != ST_EPROG) begin
                    ser_r <= 1'b0;
                end
            end
            // pause stays writable under the lock so a running job can be halted
            if (accept) begin
                pause_r <= 1'b0;
            end else if (wr && wb_adr_i == OFF_CTL_HI && wb_sel_i[1]) begin
                pause_r <= wd[CH_PAUSE];
            end
        end
    end

    // error register: outcome parked until busy is low; set wins over clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            err_r <= 2'b00;
            pend_r <= 2'b00;
        end else begin
            if (finish) begin
                pend_r <= pend_r | {bad_r, eng_fail_i || bad_r};
            end else if (!busy_r) begin
                pend_r <= 2'b00;
            end
            if (!busy_r) begin
                if (reg_wr(wr, lock_r, wb_adr_i, OFF_ERR) && wb_sel_i[0]) begin
                    err_r <= (err_r & wd[1:0]) | pend_r;
                end else begin
                    err_r <= err_r | pend_r;
                end
            end
        end
    end

    // data, address and sector select registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            d0_r <= {DATA_RST, DATA_RST};
            d1_r <= {DATA_RST, DATA_RST};
            a_r <= 24'h0;
            sect_r <= '0;
        end else begin
            if (reg_wr(wr, lock_r, wb_adr_i, OFF_D0_LO)) begin
                d0_r[15:0] <= merge(d0_r[15:0], wd, wb_sel_i);
            end
            if (reg_wr(wr, lock_r, wb_adr_i, OFF_D0_HI)) begin
                d0_r[31:16] <= merge(d0_r[31:16], wd, wb_sel_i);
            end
            if (reg_wr(wr, lock_r, wb_adr_i, OFF_D1_LO)) begin
                d1_r[15:0] <= merge(d1_r[15:0], wd, wb_sel_i);
            end
            if (reg_wr(wr, lock_r, wb_adr_i, OFF_D1_HI)) begin
                d1_r[31:16] <= merge(d1_r[31:16], wd, wb_sel_i);
            end
            if (reg_wr(wr, lock_r, wb_adr_i, OFF_ADR_LO)) begin
                a_r[15:0] <= merge(a_r[15:0], wd, wb_sel_i);
            end
            if (reg_wr(wr, lock_r, wb_adr_i, OFF_ADR_HI) && wb_sel_i[0]) begin
                a_r[23:16] <= wd[7:0];
            end
            if (reg_wr(wr, lock_r, wb_adr_i, OFF_SECT)) begin
                sect_r <= SECT_N'(merge(16'(sect_r), wd, wb_sel_i));
            end
        end
    end

    // read mux
    always_comb begin
        rdata = 32'h0;
        if (lock_r && locked_reg(wb_adr_i)) begin
            rdata[15:0] = INVALID_DAT;
        end else begin
            case (wb_adr_i)
                OFF_CTL_LO: begin
                    rdata[CL_LOCK] = lock_r;
                    rdata[CL_BUSY] = busy_r && !lock_r;
                end
                OFF_CTL_HI: rdata[15:0] = {start_r, pause_r, wpg_r, double_word_prog_select_r, ser_r, 2'b00,
                                           spr_r, 8'h00};
                OFF_D0_LO: rdata[15:0] = d0_r[15:0];
                OFF_D0_HI: rdata[15:0] = d0_r[31:16];
                OFF_D1_LO: rdata[15:0] = d1_r[15:0];
                OFF_D1_HI: rdata[15:0] = d1_r[31:16];
                OFF_ADR_LO: rdata[15:0] = a_r[15:0];
                OFF_ADR_HI: rdata[7:0] = a_r[23:16];
                OFF_ERR: rdata[1:0] = err_r;
                OFF_SECT: rdata[SECT_N-1:0] = sect_r;
                default: rdata = 32'h0;
            endcase
        end
    end

    // bank access guard and trap
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trap_r <= 1'b0;
            wr_ok_r <= 1'b0;
        end else begin
            trap_r <= (bank_rd_i && busy_r) || (rd && lock_r && locked_reg(wb_adr_i));
            wr_ok_r <= bank_wr_i && !busy_r;
        end
    end

    assign trap_o = trap_r;
    assign bank_wr_ok_o = wr_ok_r;
    assign eng_go_o = go_r;
    assign eng_op_o = op_r;
    assign eng_hold_o = hold_r;
    assign eng_addr_o = a_r;
    assign eng_data_o = {d1_r, d0_r};
    assign eng_sect_o = sect_r;
endmodule
`default_nettype wire

// >>> bench/fwc_ctrl_asserts.sv
// port assertions for the flash write command control block
// assumes a bind onto fwc_ctrl, one clock, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module fwc_ctrl_asserts
    import fwc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic wb_ack_o,
    input wire logic bank_rd_i,
    input wire logic bank_wr_i,
    input wire logic bank_wr_ok_o,
    input wire logic trap_o,
    input wire logic eng_go_o,
    input wire fwc_op_e eng_op_o,
    input wire logic eng_hold_o,
    input wire logic [63:0] eng_data_o,
    input wire logic eng_done_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic rd_take;
    logic ctl_wr;
    assign rd_take = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
    assign ctl_wr = wb_cyc_i & wb_stb_i & wb_we_i & (wb_adr_i == OFF_CTL_HI);
    a_ack_after_take: assert property (
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("ack missing");
    a_ack_one_pulse: assert property (
        wb_ack_o |=> !wb_ack_o) else $error("ack held");
    a_bank_wr_cause: assert property (
        bank_wr_ok_o |-> $past(bank_wr_i)) else $error("bank write pass without write");
    a_trap_cause: assert property (
        trap_o |-> $past(bank_rd_i) || $past(rd_take)) else $error("trap without read");
    a_go_cause: assert property (
        eng_go_o |-> $past(ctl_wr) || $past(eng_done_i) || $past(eng_done_i, 2))
        else $error("go without start");
    a_go_op_legal: assert property (
        eng_go_o |-> eng_op_o inside {OP_WORD, OP_DWORD, OP_PREP, OP_ERASE, OP_PROT})
        else $error("go with no operation");
    a_hold_rise_cause: assert property (
        $rose(eng_hold_o) |-> $past(ctl_wr) || $past(eng_done_i)) else $error("hold unasked");
    a_hold_fall_cause: assert property (
        $fell(eng_hold_o) |-> $past(ctl_wr)) else $error("hold left without resume");
    a_reset_out_values: assert property (
        $past(rst_i) |-> !eng_go_o && !eng_hold_o && !trap_o && eng_data_o == '1)
        else $error("bad reset outputs");
    c_erase_go: cover property (eng_go_o && eng_op_o == OP_ERASE);
    c_hold: cover property ($rose(eng_hold_o));
    c_trap: cover property (trap_o);
endmodule
bind fwc_ctrl fwc_ctrl_asserts fwc_ctrl_asserts_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_ack_o(wb_ack_o), .bank_rd_i(bank_rd_i), .bank_wr_i(bank_wr_i),
    .bank_wr_ok_o(bank_wr_ok_o), .trap_o(trap_o), .eng_go_o(eng_go_o),
    .eng_op_o(eng_op_o), .eng_hold_o(eng_hold_o), .eng_data_o(eng_data_o),
    .eng_done_i(eng_done_i));
`default_nettype wire

// >>> bench/fwc_ctrl_tb.sv
// self-checking bench for the flash write command control block
// assumes the bench plays cpu, wishbone master and program/erase engine
`timescale 1ns/1ps
`default_nettype none
module fwc_ctrl_tb;
    import fwc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic bank_rd = 1'b0;
    logic bank_wr = 1'b0;
    logic done = 1'b0;
    logic ack, wr_ok, trap, go, hold;
    fwc_op_e op;
    logic [23:0] eaddr;
    logic [63:0] edata;
    logic [7:0] esect;
    logic [15:0] q;
    logic tr;
    int error_cnt = 0;
    int total_checks = 0;
    int go_cnt = 0;
    int seen = 0;
    fwc_op_e go_op;
    // go is a one-cycle pulse that often falls inside a bus cycle, so count it here
    always @(posedge clk_i) begin
        if (go === 1'b1) begin
            go_cnt <= go_cnt + 1;
            go_op <= op;
        end
    end
    int bad_bit [3] = '{CH_SPR, CH_WPG, CH_DOUBLE_WORD_PROG_SELECT};
    logic [23:0] bad_adr [3] = '{24'h010000, 24'h000100, 24'h010004};
    always #50 clk_i = ~clk_i;
    fwc_ctrl #(.SECT_N(8)) fwc_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .bank_rd_i(bank_rd), .bank_wr_i(bank_wr),
        .bank_wr_ok_o(wr_ok), .trap_o(trap), .eng_go_o(go), .eng_op_o(op),
        .eng_hold_o(hold), .eng_addr_o(eaddr), .eng_data_o(edata), .eng_sect_o(esect),
        .eng_done_i(done), .eng_fail_i(1'b0));
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one classic cycle; request held until ack is sampled, then a gap cycle
    task automatic wb(input logic [7:0] a, input logic w, input logic [15:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {16'h0000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat[15:0];
        tr = trap;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 20) begin
            error_cnt++;
            finish_test();
        end
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic et, input string nm);
        wb(a, 1'b0, 16'h0);
        chk(nm, e, q);
        chk("trap", et, tr);
    endtask
    task automatic wait_go(input fwc_op_e e);
        int n;
        n = 0;
        while (go_cnt == seen && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 20) begin
            error_cnt++;
            finish_test();
        end
        chk("go_cnt", seen + 1, go_cnt);
        chk("op", e, go_op);
        seen = go_cnt;
    endtask
    // lock falls a cycle after busy; wait so later register accesses are not dropped
    task automatic pulse_done();
        done <= 1'b1;
        @(posedge clk_i);
        done <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    task automatic bank(input logic r, input logic e);
        bank_rd <= r;
        bank_wr <= !r;
        @(posedge clk_i);
        bank_rd <= 1'b0;
        bank_wr <= 1'b0;
        @(posedge clk_i);
        chk(r ? "trap" : "wr_ok", e, r ? trap : wr_ok);
    endtask
    task automatic start(input int b, input logic [23:0] a);
        wb(OFF_ADR_LO, 1'b1, a[15:0]);
        wb(OFF_ADR_HI, 1'b1, {8'h00, a[23:16]});
        wb(OFF_CTL_HI, 1'b1, 16'h8000 | (16'h0001 << b));
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(OFF_CTL_LO, 16'h0000, 1'b0, "ctl_lo");
        rd(OFF_CTL_HI, 16'h0000, 1'b0, "ctl_hi");
        rd(OFF_D1_LO, DATA_RST, 1'b0, "d1_lo");
        rd(8'h30, 16'h0000, 1'b0, "unmapped");
        wb(OFF_D0_LO, 1'b1, 16'h1234);
        wb(OFF_D0_HI, 1'b1, 16'h5678);
        wb(OFF_D1_LO, 1'b1, 16'h9abc);
        wb(OFF_D1_HI, 1'b1, 16'hdef0);
        start(CH_WPG, 24'h010004);
        wait_go(OP_WORD);
        chk("addr", 24'h010004, eaddr);
        chk("data", 64'hdef09abc56781234, edata);
        rd(OFF_CTL_LO, 16'h0010, 1'b0, "lock");
        rd(OFF_D0_LO, INVALID_DAT, 1'b1, "locked");
        wb(OFF_D0_LO, 1'b1, 16'h0000);
        bank(1'b1, 1'b1);
        bank(1'b0, 1'b0);
        pulse_done();
        repeat (2) @(posedge clk_i);
        rd(OFF_CTL_HI, 16'h0000, 1'b0, "ctl_hi");
        rd(OFF_D0_LO, 16'h1234, 1'b0, "d0_lo");
        rd(OFF_ERR, 16'h0000, 1'b0, "err");
        bank(1'b1, 1'b0);
        bank(1'b0, 1'b1);
        start(CH_DOUBLE_WORD_PROG_SELECT, 24'h010008);
        wait_go(OP_DWORD);
        pulse_done();
        start(CH_SPR, 24'h08e000);
        wait_go(OP_PROT);
        pulse_done();
        rd(OFF_CTL_HI, 16'h0000, 1'b0, "ctl_hi");
        // refused targets, then a start with the error flag still high
        for (int i = 0; i < 3; i++) begin
            start(bad_bit[i], bad_adr[i]);
            repeat (2) @(posedge clk_i);
            rd(OFF_ERR, 16'h0003, 1'b0, "seq_err");
            start(CH_WPG, 24'h010000);
            rd(OFF_CTL_LO, 16'h0000, 1'b0, "refused");
            wb(OFF_ERR, 1'b1, 16'h0000);
        end
        wb(OFF_SECT, 1'b1, 16'h0001);
        start(CH_SER, 24'h010000);
        wait_go(OP_PREP);
        chk("sect", 8'h01, esect);
        pulse_done();
        wait_go(OP_ERASE);
        wb(OFF_CTL_HI, 1'b1, 16'h4000);
        chk("hold", 1'b1, hold);
        bank(1'b1, 1'b0);
        start(CH_WPG, 24'h010010);
        wait_go(OP_WORD);
        pulse_done();
        @(posedge clk_i);
        chk("hold", 1'b1, hold);
        wb(OFF_CTL_HI, 1'b1, 16'h8000 | (16'h0001 << CH_SER));
        chk("hold", 1'b0, hold);
        wait_go(OP_ERASE);
        bank(1'b1, 1'b1);
        pulse_done();
        repeat (2) @(posedge clk_i);
        rd(OFF_CTL_HI, 16'h0000, 1'b0, "ctl_hi");
        start(CH_WPG, 24'h010000);
        wait_go(OP_WORD);
        wb(OFF_CTL_HI, 1'b1, 16'h4000);
        chk("hold", 1'b1, hold);
        wb(OFF_CTL_HI, 1'b1, 16'h8000 | (16'h0001 << CH_DOUBLE_WORD_PROG_SELECT));
        chk("hold", 1'b1, hold);
        wb(OFF_CTL_HI, 1'b1, 16'h8000 | (16'h0001 << CH_WPG));
        chk("hold", 1'b0, hold);
        pulse_done();
        repeat (2) @(posedge clk_i);
        rd(OFF_CTL_LO, 16'h0000, 1'b0, "ctl_lo");
        // pause left set by software blocks a new start
        wb(OFF_CTL_HI, 1'b1, 16'h4000);
        wb(OFF_CTL_HI, 1'b1, 16'hc000 | (16'h0001 << CH_WPG));
        rd(OFF_CTL_LO, 16'h0000, 1'b0, "paused");
        finish_test();
    end
endmodule
`default_nettype wire
